// file: pwrctl_pkg.sv
package pwrctl_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] PWRCTL_CTRL_OFS = 8'h00;
  localparam logic [7:0] PWRCTL_STAT_OFS = 8'h04;

  // Control register fields
  localparam int CTRL_SLOW_BIT   = 0;
  localparam int CTRL_AWU_BIT    = 1;
  localparam int CTRL_TB_IE_BIT  = 2;
  localparam int CTRL_OVF_IE_BIT = 3;
  localparam int CTRL_CK0_BIT    = 4;
  localparam int CTRL_CK1_BIT    = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;

  // Status register fields
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_SLOW_BIT = 3;
  localparam int STAT_OSC_BIT  = 4;
  localparam int STAT_LONG_BIT = 5;
  localparam int STAT_PLL_BIT  = 6;

  // ----------------------------------------------------------------
  // Instruction and timing constants
  // ----------------------------------------------------------------
  localparam logic [7:0] HALT_OPCODE  = 8'h8E;
  localparam int SLOW_DIV             = 32;
  localparam int STAB_SHORT_CYC       = 256;
  localparam int STAB_LONG_CYC        = 4096;
  localparam int CLK_PERIOD_NS        = 10;
  localparam int PLL_STARTUP_NS       = 1000;
  localparam int STRAP_CAPTURE_CYC    = 2;
  localparam int CNT_W                = 16;

  // Least time rounds up, never below one cycle
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // Power modes
  typedef enum logic [2:0] {
    ST_STRAP, ST_START, ST_PLL, ST_RUN, ST_WAIT, ST_HALT, ST_ACTHALT, ST_AUTO_WAKE_FROM_HALT
  } pwrctl_state_e;

endpackage

// file: pwrctl_clk_if.sv
`timescale 1ns/10ps
// Clock enable hand-off between the mode controller and the divider
interface pwrctl_clk_if;
  logic osc_run;
  logic slow_sel;
  logic tick;
  modport ctl (output osc_run, output slow_sel, input tick);
  modport div (input osc_run, input slow_sel, output tick);
endinterface

// file: pwrctl_clkdiv.sv
`timescale 1ns/10ps
module pwrctl_clkdiv
  import pwrctl_pkg::*;
#(
  parameter int DIV = SLOW_DIV
)(
  input  wire logic   hclk,
  input  wire logic   hresetn,
  pwrctl_clk_if.div   cif
);

  logic [$clog2(DIV)-1:0] cnt_r;

  // ----------------------------------------------------------------
  // Divide counter
  // ----------------------------------------------------------------
  // Held at zero outside slow so the first slow tick is a full period
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_r <= '0;
    else if (!cif.osc_run || !cif.slow_sel)
      cnt_r <= '0;
    else
      cnt_r <= cnt_r + 1'b1;
  end

  // Master rate every cycle, slow rate once per wrap
  assign cif.tick = cif.osc_run && (!cif.slow_sel || (&cnt_r));

endmodule

// file: pwrctl_top.sv
`timescale 1ns/10ps
// Overview of operation
// - Reset always ends in RUN, clocking everything at master rate.
// - Slow select divides CPU and peripheral clock by 32; clearing restores.
// - Wait-for-interrupt during slow gives slow-wait: peripherals keep divided clock.
// - Wait stops only the CPU clock; peripherals keep running.
// - Entering wait clears the interrupt mask bit.
// - Wait lasts until interrupt or reset, then CPU restarts at a vector.
// - Interrupt wake-up tells the CPU to push condition codes and mask.
// - Full halt only when active-halt and auto-wake are both off.
// - Halt wake restarts oscillator and counts 256 or 4096 cycles first.
// - Entering halt clears the mask so a pending interrupt wakes at once.
// - In halt the oscillator is off and no CPU or peripheral clock runs.
// - Watchdog-halt option picks watchdog reset or normal halt.
// - With PLL enabled, add a PLL start-up interval after wake-up.
// - Opcode 0x8E is decoded as the halt instruction.
// - Timebase enable, or overflow enable with clock select 01, gives active-halt.
// - Auto-wake enable turns halt into auto-wake-from-halt.
module pwrctl_top
  import pwrctl_pkg::*;
#(
  parameter int PLL_NS = PLL_STARTUP_NS
)(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        opcode_valid,
  input  wire logic [7:0]  opcode,
  input  wire logic        wait_for_interrupt_instr,
  input  wire logic        irq_pending,
  input  wire logic        irq_wake_halt,
  input  wire logic        irq_wake_active,
  input  wire logic        awu_irq,
  input  wire logic        watchdog_enabled,
  input  wire logic        stab_long_strap,
  input  wire logic        watchdog_halt_option,
  input  wire logic        pll_enable_option,
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             timer_clk_en,
  output logic             osc_enable,
  output logic             pll_clk_en,
  output logic             imask_clear,
  output logic             cpu_restart,
  output logic             restart_from_irq,
  output logic             irq_service,
  output logic             watchdog_reset_req,
  output logic [2:0]       power_mode
);

  localparam int PLL_CYC = ns_to_cyc(PLL_NS);
  localparam logic [CNT_W-1:0] STAB_SHORT_LD = CNT_W'(STAB_SHORT_CYC - 1);
  localparam logic [CNT_W-1:0] STAB_LONG_LD  = CNT_W'(STAB_LONG_CYC - 1);
  localparam logic [CNT_W-1:0] PLL_LD        = CNT_W'(PLL_CYC - 1);
  localparam logic [1:0]       STRAP_AT      = 2'(STRAP_CAPTURE_CYC);

  pwrctl_state_e    state_r;
  pwrctl_state_e    state_nxt;
  logic [5:0]       ctrl_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] boot_cnt_r;
  logic [2:0]       sync1_r;
  logic [2:0]       sync2_r;
  logic [1:0]       strap_cnt_r;
  logic             stab_long_r;
  logic             wdg_halt_rst_r;
  logic             pll_en_r;
  logic             wake_irq_r;
  logic             ap_valid_r;
  logic             ap_write_r;
  logic [7:0]       ap_addr_r;
  logic             halt_cmd;
  logic             act_halt_en;
  logic             wdg_trip;
  logic             ap_take;
  logic             restart_now;
  logic             restart_irq_now;
  logic             clk_on;

  pwrctl_clk_if cif ();

  // ----------------------------------------------------------------
  // Option pins: two-stage sync, then caught once after reset release
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end
    else
    begin
      sync1_r <= {pll_enable_option, watchdog_halt_option, stab_long_strap};
      sync2_r <= sync1_r;
    end
  end

  // Frozen until the next reset; late pin changes are ignored
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      strap_cnt_r    <= 2'h0;
      stab_long_r    <= 1'b0;
      wdg_halt_rst_r <= 1'b0;
      pll_en_r       <= 1'b0;
    end
    else if (strap_cnt_r != STRAP_AT)
      strap_cnt_r <= strap_cnt_r + 2'h1;
    else if (state_r == ST_STRAP)
    begin
      stab_long_r    <= sync2_r[0];
      wdg_halt_rst_r <= sync2_r[1];
      pll_en_r       <= sync2_r[2];
    end
  end

  // ----------------------------------------------------------------
  // Halt decision
  // ----------------------------------------------------------------
  assign halt_cmd    = opcode_valid && (opcode == HALT_OPCODE);
  assign act_halt_en = ctrl_r[CTRL_TB_IE_BIT] ||
                       (ctrl_r[CTRL_OVF_IE_BIT] && !ctrl_r[CTRL_CK1_BIT] &&
                        ctrl_r[CTRL_CK0_BIT]);
  // Active-halt wins over the watchdog reset option
  assign wdg_trip    = halt_cmd && watchdog_enabled && wdg_halt_rst_r && !act_halt_en;

  // ----------------------------------------------------------------
  // Mode state machine
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_STRAP:
        if (strap_cnt_r == STRAP_AT)
          state_nxt = ST_START;
      ST_START:
        if (cnt_r == '0)
          state_nxt = pll_en_r ? ST_PLL : ST_RUN;
      ST_PLL:
        if (cnt_r == '0)
          state_nxt = ST_RUN;
      ST_RUN:
        if (wait_for_interrupt_instr)
          state_nxt = ST_WAIT;
        else if (halt_cmd && !wdg_trip)
        begin
          if (act_halt_en)
            state_nxt = ST_ACTHALT;
          else if (ctrl_r[CTRL_AWU_BIT])
            state_nxt = ST_AUTO_WAKE_FROM_HALT;
          else
            state_nxt = ST_HALT;
        end
      ST_WAIT:
        if (irq_pending)
          state_nxt = ST_RUN;
      ST_HALT:
        if (irq_wake_halt)
          state_nxt = ST_START;
      ST_AUTO_WAKE_FROM_HALT:
        if (irq_wake_halt || awu_irq)
          state_nxt = ST_START;
      ST_ACTHALT:
        if (irq_wake_active)
          state_nxt = ST_RUN;
      default:
        state_nxt = ST_START;
    endcase
  end

  // Reset lands in the strap window, then stabilises, then RUN
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_r <= ST_STRAP;
    else
      state_r <= state_nxt;
  end

  // ----------------------------------------------------------------
  // Stabilisation and PLL counter
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_r <= '0;
    else if (state_nxt == ST_START && state_r != ST_START)
      cnt_r <= (state_r == ST_STRAP ? sync2_r[0] : stab_long_r) ?
               STAB_LONG_LD : STAB_SHORT_LD;
    else if (state_nxt == ST_PLL && state_r != ST_PLL)
      cnt_r <= PLL_LD;
    else if (cnt_r != '0)
      cnt_r <= cnt_r - 1'b1;
  end

  // Remembers what woke a halt: reset or interrupt
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wake_irq_r <= 1'b0;
    else if ((state_r == ST_HALT || state_r == ST_AUTO_WAKE_FROM_HALT) && state_nxt == ST_START)
      wake_irq_r <= 1'b1;
    else if (state_r == ST_RUN)
      wake_irq_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Restart, mask and watchdog pulses
  // ----------------------------------------------------------------
  assign restart_now     = (state_nxt == ST_RUN) && (state_r != ST_RUN);
  assign restart_irq_now = (state_r == ST_WAIT) || (state_r == ST_ACTHALT) || wake_irq_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cpu_restart        <= 1'b0;
      restart_from_irq   <= 1'b0;
      irq_service        <= 1'b0;
      imask_clear        <= 1'b0;
      watchdog_reset_req <= 1'b0;
    end
    else
    begin
      cpu_restart        <= restart_now;
      irq_service        <= restart_now && restart_irq_now;
      imask_clear        <= (state_r == ST_RUN) && (state_nxt != ST_RUN);
      watchdog_reset_req <= (state_r == ST_RUN) && wdg_trip && !wait_for_interrupt_instr;
      if (restart_now)
        restart_from_irq <= restart_irq_now;
    end
  end

  // ----------------------------------------------------------------
  // Clock gating
  // ----------------------------------------------------------------
  // Slow setting lives in ctrl_r, untouched by wait entry or exit
  assign clk_on       = (state_r == ST_RUN) || (state_r == ST_WAIT) ||
                        (state_r == ST_ACTHALT);
  assign cif.osc_run  = clk_on;
  assign cif.slow_sel = ctrl_r[CTRL_SLOW_BIT];

  pwrctl_clkdiv #(
    .DIV (SLOW_DIV)
  ) u_div (
    .hclk    (hclk),
    .hresetn (hresetn),
    .cif     (cif)
  );

  assign cpu_clk_en    = cif.tick && (state_r == ST_RUN);
  // Slow wait: same divided tick, CPU gated off
  assign periph_clk_en = cif.tick && (state_r == ST_RUN || state_r == ST_WAIT);
  assign timer_clk_en  = cif.tick;
  assign osc_enable    = (state_r != ST_HALT) && (state_r != ST_AUTO_WAKE_FROM_HALT);
  assign pll_clk_en    = clk_on;
  assign power_mode    = state_r;

  // ----------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // ----------------------------------------------------------------
  assign ap_take   = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_valid_r <= 1'b0;
      ap_write_r <= 1'b0;
      ap_addr_r  <= 8'h00;
    end
    else
    begin
      ap_valid_r <= ap_take;
      ap_write_r <= hwrite;
      ap_addr_r  <= haddr[7:0];
    end
  end

  // Control register written in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_r <= CTRL_RESET;
    else if (ap_valid_r && ap_write_r && ap_addr_r == PWRCTL_CTRL_OFS)
      ctrl_r <= hwdata[5:0];
  end

  // Read data registered at the address phase; unmapped reads zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (ap_take && !hwrite)
    begin
      hrdata <= 32'h0000_0000;
      if (haddr[7:0] == PWRCTL_CTRL_OFS)
        hrdata[5:0] <= ctrl_r;
      else if (haddr[7:0] == PWRCTL_STAT_OFS)
      begin
        hrdata[STAT_MODE_LSB +: 3] <= state_r;
        hrdata[STAT_SLOW_BIT]      <= ctrl_r[CTRL_SLOW_BIT];
        hrdata[STAT_OSC_BIT]       <= osc_enable;
        hrdata[STAT_LONG_BIT]      <= stab_long_r;
        hrdata[STAT_PLL_BIT]       <= pll_en_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Boot and wake cycles, saturating, so a stuck start-up is caught
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      boot_cnt_r <= '0;
    else if (state_r == ST_STRAP || state_r == ST_START || state_r == ST_PLL)
      boot_cnt_r <= boot_cnt_r + CNT_W'(boot_cnt_r != '1);
    else
      boot_cnt_r <= '0;

  sequence s_halt_entry;
    (state_r == ST_RUN) && halt_cmd && !wdg_trip && !wait_for_interrupt_instr;
  endsequence
  sequence s_halt_wake;
    (state_r == ST_HALT) && irq_wake_halt;
  endsequence

  a_run_after_reset: assert property (int'(boot_cnt_r) <= STAB_LONG_CYC + PLL_CYC + 8)
    else $error("RUN not reached after reset");
  a_slow_tick_gap: assert property (
    cpu_clk_en && ctrl_r[CTRL_SLOW_BIT] && $stable(ctrl_r)
      |-> ##1 (!cpu_clk_en || !ctrl_r[CTRL_SLOW_BIT])[*8])
    else $error("slow tick too frequent");
  a_wait_gates_cpu: assert property (
    state_r == ST_WAIT |-> !cpu_clk_en && (periph_clk_en == cif.tick))
    else $error("wait clock gating wrong");
  a_wait_mask_clear: assert property (
    (state_r == ST_RUN) && wait_for_interrupt_instr |-> ##1 imask_clear)
    else $error("mask not cleared on wait");
  a_wait_wake_restart: assert property (
    (state_r == ST_WAIT) && irq_pending |-> ##1 cpu_restart && irq_service)
    else $error("wait wake restart missing");
  a_halt_mask_clear: assert property (s_halt_entry |-> ##1 imask_clear)
    else $error("mask not cleared on halt");
  a_halt_no_clock: assert property (
    state_r == ST_HALT |-> !osc_enable && !cpu_clk_en && !periph_clk_en)
    else $error("clock running in halt");
  a_halt_stab_wait: assert property (
    s_halt_wake |-> ##1 (osc_enable && !cpu_restart)[*8])
    else $error("halt wake skipped stabilisation");
  a_wdg_reset: assert property (
    (state_r == ST_RUN) && wdg_trip && !wait_for_interrupt_instr
      |-> ##1 watchdog_reset_req && state_r == ST_RUN)
    else $error("watchdog reset not raised");
  a_halt_opcode: assert property (
    (state_r == ST_RUN) && opcode_valid && opcode != HALT_OPCODE &&
      !wait_for_interrupt_instr |-> ##1 state_r == ST_RUN)
    else $error("non-halt opcode left RUN");

endmodule

// file: pwrctl_cpu_model.sv
`timescale 1ns/10ps
// CPU stand-in: opcode strobes and the I bit of the condition codes
module pwrctl_cpu_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       imask_clear,
  input  wire logic       irq_service,
  output logic            opcode_valid,
  output logic [7:0]      opcode,
  output logic            wait_for_interrupt_instr,
  output logic            imask_r
);
  // Strobes idle at time zero
  initial
  begin
    opcode_valid = 1'b0;
    opcode = 8'h00;
    wait_for_interrupt_instr = 1'b0;
  end

  // Mask set while servicing, cleared when the block asks
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) imask_r <= 1'b1;
    else if (irq_service) imask_r <= 1'b1;
    else if (imask_clear) imask_r <= 1'b0;

  // One-cycle strobe; byte inverted after so a stale value never lingers
  task automatic exec_op(input logic [7:0] op);
    @(posedge hclk);
    opcode_valid <= 1'b1;
    opcode <= op;
    @(posedge hclk);
    opcode_valid <= 1'b0;
    opcode <= ~op;
  endtask

  // Wait-for-interrupt strobe, one cycle
  task automatic exec_wfi();
    @(posedge hclk);
    wait_for_interrupt_instr <= 1'b1;
    @(posedge hclk);
    wait_for_interrupt_instr <= 1'b0;
  endtask
endmodule

// file: pwrctl_top_tb.sv
`timescale 1ns/10ps
module pwrctl_top_tb;
  import pwrctl_pkg::*;
  localparam int PNS = 50;
  localparam int PCYC = (PNS + 9) / 10;
  localparam logic [29:0] TBL = {6'h38, 6'h18, 6'h04, 6'h02, 6'h00};
  logic        hclk, hreadyout, hresp, i_bit;
  logic        hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [1:0]  htrans = 2'h0;
  logic        opcode_valid, wait_for_interrupt_instr;
  logic [7:0]  opcode;
  logic        irq_pending = 1'b0, irq_wake_halt = 1'b0;
  logic        irq_wake_active = 1'b0, awu_irq = 1'b0, watchdog_enabled = 1'b0;
  logic        stab_long_strap = 1'b0, watchdog_halt_option = 1'b0;
  logic        pll_enable_option = 1'b0;
  logic        cpu_clk_en, periph_clk_en, timer_clk_en, osc_enable, pll_clk_en;
  logic        imask_clear, cpu_restart, restart_from_irq, irq_service;
  logic        watchdog_reset_req;
  logic [2:0]  power_mode, em;
  logic        lng = 1'b0, pll = 1'b1, wdo = 1'b1;
  int          num_errors, cmp_count, c, p, seed;

  pwrctl_top #(.PLL_NS(PNS)) u_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .opcode_valid, .opcode,
    .wait_for_interrupt_instr, .irq_pending, .irq_wake_halt, .irq_wake_active,
    .awu_irq, .watchdog_enabled, .stab_long_strap, .watchdog_halt_option,
    .pll_enable_option, .cpu_clk_en, .periph_clk_en, .timer_clk_en, .osc_enable,
    .pll_clk_en, .imask_clear, .cpu_restart, .restart_from_irq, .irq_service,
    .watchdog_reset_req, .power_mode
  );
  pwrctl_cpu_model u_cpu (
    .hclk, .hresetn, .imask_clear, .irq_service, .opcode_valid, .opcode,
    .wait_for_interrupt_instr, .imask_r(i_bit)
  );

  // 100 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // ------------------------------------------------------------
  // Checking and bus helpers
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %s exp %0h got %0h", n, e, g);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic tmo(input string n);
    chk(n, 1, 0);
    test_done();
  endtask

  // Hang guard far above the longest expected run
  initial
  begin
    repeat (100000) @(posedge hclk);
    tmo("run timeout");
  end

  task automatic rdy();
    @(posedge hclk);
    for (int k = 0; hreadyout !== 1'b1; k++)
      if (k > 50) tmo("hready");
      else @(posedge hclk);
  endtask

  // Single word transfer; read data lands in r
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    r = hrdata;
    chk("hresp", 0, hresp);
  endtask

  task automatic wmode(input logic [2:0] m, input int lim);
    @(negedge hclk);
    for (int k = 0; power_mode !== m; k++)
      if (k > lim) tmo("mode");
      else @(negedge hclk);
  endtask

  // Negedges spent in a mode, sampled where outputs are settled
  task automatic dwell(input logic [2:0] m, output int n);
    for (n = 0; power_mode === m; n++)
      if (n > 5000) tmo("dwell");
      else @(negedge hclk);
  endtask

  task automatic cnt(input int n);
    c = 0;
    p = 0;
    repeat (n)
    begin
      @(negedge hclk);
      c += int'(cpu_clk_en === 1'b1);
      p += int'(periph_clk_en === 1'b1);
    end
  endtask

  function automatic logic [2:0] exp_halt(input logic [5:0] k);
    if (k[2] || (k[3] && !k[5] && k[4])) return ST_ACTHALT;
    if (k[1]) return ST_AUTO_WAKE_FROM_HALT;
    return ST_HALT;
  endfunction

  // Oscillator start, stabilisation, optional PLL wait, then restart
  task automatic stab(input int lim, input logic irq);
    wmode(ST_START, lim);
    chk("osc on", 2'h2, {osc_enable, pll_clk_en});
    dwell(ST_START, c);
    chk("stab cycles", lng ? 4096 : 256, c);
    dwell(ST_PLL, c);
    chk("pll cycles", pll ? PCYC : 0, c);
    chk("restart", {ST_RUN, 1'b1, irq, irq, 1'b1},
        {power_mode, cpu_restart, restart_from_irq, irq_service, pll_clk_en});
  endtask

  task automatic boot();
    @(posedge hclk);
    hresetn <= 1'b0;
    stab_long_strap <= lng;
    watchdog_halt_option <= wdo;
    pll_enable_option <= pll;
    repeat (3) @(posedge hclk);
    @(negedge hclk);
    chk("reset outs", {ST_STRAP, 4'hC},
        {power_mode, osc_enable, hreadyout, cpu_clk_en, cpu_restart});
    @(posedge hclk);
    hresetn <= 1'b1;
    stab(20, 1'b0);
  endtask

  // Table then random halt decisions, with watchdog on or off; each halt entered is woken again
  task automatic halts(input int n);
    logic [5:0] ct;
    logic       wd;
    for (int i = 0; i < n; i++)
    begin
      ct = 6'($urandom);
      if (i < 5) ct = TBL[6*i +: 6];
      ct[CTRL_SLOW_BIT] = 1'b0;  // Slow would thin the timer tick checked below
      wd = 1'($urandom);
      @(posedge hclk);
      watchdog_enabled <= wd;
      bus(1'b1, PWRCTL_CTRL_OFS, {26'h0, ct});
      em = exp_halt(ct);
      u_cpu.exec_op(8'h8E);
      @(negedge hclk);
      if (wd && wdo && em != ST_ACTHALT)
        chk("wdog", {1'b1, ST_RUN}, {watchdog_reset_req, power_mode});
      else
      begin
        chk("entry", {1'b1, em}, {imask_clear, power_mode});
        if (em == ST_ACTHALT)
        begin
          chk("act clk", 4'h9, {osc_enable, cpu_clk_en, periph_clk_en, timer_clk_en});
          @(posedge hclk);
          irq_wake_active <= 1'b1;
          wmode(ST_RUN, 3);
          chk("act wake", 3'h7, {cpu_restart, irq_service, restart_from_irq});
        end
        else
        begin
          chk("halt clk", 4'h0, {osc_enable, cpu_clk_en, periph_clk_en, timer_clk_en});
          @(posedge hclk);
          awu_irq <= (em == ST_AUTO_WAKE_FROM_HALT);
          irq_wake_halt <= (em != ST_AUTO_WAKE_FROM_HALT);
          stab(3, 1'b1);
        end
        @(posedge hclk);
        {awu_irq, irq_wake_halt, irq_wake_active} <= 3'h0;
      end
    end
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    seed = $urandom(65);
    boot();
    $display("test boot done");
    bus(1'b0, PWRCTL_CTRL_OFS, 0);
    chk("ctrl rst", 0, r);
    bus(1'b1, PWRCTL_CTRL_OFS, 32'hFFFFFFFF);
    bus(1'b0, PWRCTL_CTRL_OFS, 0);
    chk("ctrl rw", 32'h3F, r);
    bus(1'b1, 8'h08, 32'hFFFFFFFF);
    bus(1'b0, 8'h08, 0);
    chk("unmapped", 0, r);
    bus(1'b1, PWRCTL_CTRL_OFS, 32'h1);
    bus(1'b0, PWRCTL_STAT_OFS, 0);
    chk("status", {pll, lng, 2'h3, ST_RUN}, r);
    $display("test registers done");
    cnt(64);
    chk("slow cpu", 2, c);
    chk("slow per", 2, p);
    u_cpu.exec_wfi();
    @(negedge hclk);
    chk("wait in", {1'b1, ST_WAIT}, {imask_clear, power_mode});
    cnt(64);
    chk("sw cpu", 0, c);
    chk("sw per", 2, p);
    chk("i bit clr", 0, i_bit);
    @(posedge hclk);
    irq_pending <= 1'b1;
    wmode(ST_RUN, 3);
    chk("wait wake", 3'h7, {cpu_restart, irq_service, restart_from_irq});
    @(posedge hclk);
    irq_pending <= 1'b0;
    cnt(64);
    chk("i bit set", 1, i_bit);
    chk("slow kept", 2, c);
    bus(1'b1, PWRCTL_CTRL_OFS, 0);
    cnt(64);
    chk("run cpu", 64, c);
    $display("test slow and wait done");
    repeat (4)
    begin
      r = $urandom;
      u_cpu.exec_op((r[7:0] == HALT_OPCODE) ? 8'h00 : r[7:0]);
      @(negedge hclk);
      chk("other op", ST_RUN, power_mode);
    end
    halts(10);
    @(posedge hclk);
    watchdog_enabled <= 1'b0;
    bus(1'b1, PWRCTL_CTRL_OFS, 0);
    irq_wake_halt <= 1'b1;
    u_cpu.exec_op(8'h8E);
    stab(4, 1'b1);
    @(posedge hclk);
    irq_wake_halt <= 1'b0;
    $display("test halt modes done");
    u_cpu.exec_wfi();
    cnt(64);
    chk("wait per", 64, p);
    chk("wait mode", ST_WAIT, power_mode);
    {lng, pll, wdo} = 3'h4;
    boot();
    @(posedge hclk);
    stab_long_strap <= 1'b0;
    repeat (8) @(posedge hclk);
    bus(1'b0, PWRCTL_STAT_OFS, 0);
    chk("strap held", {pll, lng, 2'h2, ST_RUN}, r);
    halts(3);
    $display("test long stabilisation done");
    test_done();
  end
endmodule
